// File: verilog/tec_defs.vh
// offsets, field positions, reset values and counts for the timer/event counter block
`ifndef TEC_DEFS_VH
`define TEC_DEFS_VH

// register byte offsets, one aligned 32-bit word each
`define TEC_OFF_CTRL0    5'h00
`define TEC_OFF_CTRL1    5'h04
`define TEC_OFF_CTRL2    5'h08
`define TEC_OFF_PRE0     5'h0C
`define TEC_OFF_PRE1     5'h10
`define TEC_OFF_PRE2     5'h14
`define TEC_OFF_INTEN    5'h18

// counter_control_register fields
`define TEC_MODE_HI      7
`define TEC_MODE_LO      6
`define TEC_SRC_BIT      5
`define TEC_EN_BIT       4
`define TEC_EDGE_BIT     3
`define TEC_PSC_HI       2
`define TEC_PSC_LO       0

// operating_mode_field codes
`define TEC_MODE_NONE    2'h0
`define TEC_MODE_EVT     2'h1
`define TEC_MODE_TMR     2'h2
`define TEC_MODE_PWC     2'h3

// reset values and masks
`define TEC_CTRL_RST     8'h08
`define TEC_CTRL0_MASK   8'hFF
`define TEC_CTRL12_MASK  8'hF8
`define TEC_PRE_RST      16'h0000
`define TEC_INTEN_RST    3'h0
`define TEC_MAX8         16'h00FF
`define TEC_MAX16        16'hFFFF

// system clock divided by four: terminal count of a 2-bit divider
`define TEC_DIV4_LAST    2'h3
// prescaler length: ratios up to 128
`define TEC_PSC_BITS     7

`endif

// File: verilog/tec_pin_sync.v
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module tec_pin_sync (
    input  wire i_clk,   // core clock
    input  wire i_rst,   // async reset, active high
    input  wire i_pin,   // asynchronous pin level
    output wire o_rise,  // one-cycle pulse on accepted low-to-high
    output wire o_fall   // one-cycle pulse on accepted high-to-low
);

    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;

    // s1_q feeds only s2_q; the level moves only once s2_q and s3_q agree
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                lvl_q <= s3_q;
        end
    end

    // each accepted change gives exactly one pulse
    assign o_rise = (s2_q == s3_q) & s3_q & ~lvl_q;
    assign o_fall = (s2_q == s3_q) & ~s3_q & lvl_q;

endmodule // tec_pin_sync

// File: verilog/tec_prescaler.v
// power-of-two prescaler on a tick stream, ticking on the divided clock's falling edge
`timescale 1ns/1ps
`include "tec_defs.vh"
module tec_prescaler (
    input  wire       i_clk,   // core clock
    input  wire       i_rst,   // async reset, active high
    input  wire       i_tick,  // source clock tick
    input  wire [2:0] i_psc,   // ratio code, 2 to the power code
    output wire       o_tick   // prescaled tick
);

    reg  [`TEC_PSC_BITS-1:0] div_q;
    wire [`TEC_PSC_BITS-1:0] mask;

    // free-running divider stepped by the source tick
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            div_q <= {`TEC_PSC_BITS{1'b0}};
        else if (i_tick)
            div_q <= div_q + {{(`TEC_PSC_BITS-1){1'b0}}, 1'b1};
    end

    // divided bit falls when all bits below the selected one are ones; code 0 passes through
    assign mask   = {`TEC_PSC_BITS{1'b1}} >> (3'h7 - i_psc);
    assign o_tick = i_tick & (&(div_q | ~mask));

endmodule // tec_prescaler

// File: verilog/tec_top.v
// three timer/event counters with wishbone register access
//
// How it works
// - mode bits 7:6 pick event, timer, capture
// - count enable bit 4 runs or halts counting
// - counter 0 prescaler divides by two-power code
// - external pin clocking ignores the prescaler ratio
// - counter 0 bit 5 picks system or crystal
// - pwm enabled forces the shared clock to system
// - counters 1,2 use system/4 or crystal
// - counters 1,2 control bits 2:0 read zero
// - event mode edge bit 0 rising, 1 falling
// - capture edge bit picks start and stop edges
// - timer mode counts each prescaled clock fall
// - overflow raises request and reloads from preload
// - overflow wakes; enable bit zero suppresses request and wake
// - event mode clocks straight from pin edges
// - event counting continues in sleep, wakes
// - overflow after FFH or FFFFH, counting up
// - preload while stopped also loads the counter
// - capture end clears enable, ignores later edges
`timescale 1ns/1ps
`include "tec_defs.vh"
module tec_top (
    input  wire        I_CORE_CLK,  // core clock, 125 MHz
    input  wire        I_SYS_RST,   // async reset, active high
    input  wire        I_WB_CYC,    // wishbone cycle
    input  wire        I_WB_STB,    // wishbone strobe
    input  wire        I_WB_WE,     // wishbone write enable
    input  wire [7:0]  I_WB_ADR,    // wishbone byte address
    input  wire [3:0]  I_WB_SEL,    // wishbone byte selects
    input  wire [31:0] I_WB_DAT,    // wishbone write data
    output wire [31:0] O_WB_DAT,    // wishbone read data
    output wire        O_WB_ACK,    // wishbone acknowledge
    input  wire [2:0]  I_TMR_PIN,   // external_timer_input_pin, one per counter
    input  wire        I_LXT_CLK,   // low_speed_crystal clock, asynchronous
    input  wire        I_PWM_EN,    // pwm enabled, same clock domain
    output wire [2:0]  O_TMR_IRQ,   // timer interrupt request pulses
    output wire        O_WAKE       // wake-up pulse from any enabled overflow
);

    reg  [31:0] wb_dat_q;
    reg         wb_ack_q;
    reg  [31:0] rd_d;
    reg  [2:0]  inten_q;
    reg  [2:0]  irq_q;
    reg  [1:0]  div4_q;
    reg         wake_q;

    wire        wb_req;
    wire        wb_wr;
    wire [3:0]  pin_rise;
    wire [3:0]  pin_fall;
    wire [3:0]  pin_lvl_in;
    wire [23:0] ctrl_all;
    wire [47:0] cnt_all;
    wire [2:0]  ovf_all;
    wire [2:0]  int_tick;
    wire        lxt_tick;
    wire        tp_tick;
    wire        tp_sys;
    wire        div4_tick;
    wire        tmr0_tick;
    wire [15:0] sel16;
    wire [2:0]  ovf_en;
    wire        wb_rd;

    // write decode used by every register
    function hit;
        input [4:0] off;
        input [7:0] adr;
        input       wr;
        begin
            hit = wr & (adr == {3'h0, off});
        end
    endfunction

    // mode decode shared by the count, capture-window and auto-clear logic
    function is_mode;
        input [1:0] cur;
        input [1:0] code;
        begin
            is_mode = (cur == code);
        end
    endfunction

    // a new request is taken only when no answer is pending
    assign wb_req = I_WB_CYC & I_WB_STB & ~wb_ack_q;
    assign wb_wr  = wb_req & I_WB_WE;
    assign wb_rd  = wb_req & ~I_WB_WE;
    assign sel16  = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

    // pins and crystal cross into the core domain; bit 3 is the crystal
    // two agreeing samples cost about four cycles of latency, but a glitch
    // shorter than a cycle can never count twice
    assign pin_lvl_in = {I_LXT_CLK, I_TMR_PIN};

    genvar s;
    generate
        for (s = 0; s < 4; s = s + 1)
        begin : gen_sync
            tec_pin_sync u_sync (
                .i_clk  (I_CORE_CLK),
                .i_rst  (I_SYS_RST),
                .i_pin  (pin_lvl_in[s]),
                .o_rise (pin_rise[s]),
                .o_fall (pin_fall[s])
            );
        end
    endgenerate

    // crystal clock counts on its falling edge, like the other internal clocks
    // limitation: each crystal phase must last two core cycles to be seen
    assign lxt_tick = pin_fall[3];

    // shared timer-path clock: pwm forces the system clock
    // the override covers counter 0 only; counters 1 and 2 pick their own
    assign tp_sys  = I_PWM_EN | ~ctrl_all[`TEC_SRC_BIT];
    assign tp_tick = tp_sys ? 1'b1 : lxt_tick;

    // counter 0 internal clock through the prescaler
    // the divider is not cleared by control writes, so the first prescaled
    // tick after enable may come up to one full ratio early
    tec_prescaler u_psc (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_SYS_RST),
        .i_tick (tp_tick),
        .i_psc  (ctrl_all[`TEC_PSC_HI:`TEC_PSC_LO]),
        .o_tick (tmr0_tick)
    );

    // system clock divided by four for counters 1 and 2
    // one free-running divider, so counters 1 and 2 step in the same cycle
    always @(posedge I_CORE_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            div4_q <= 2'h0;
        else
            div4_q <= div4_q + 2'h1;
    end

    assign div4_tick = (div4_q == `TEC_DIV4_LAST);

    // per-counter internal clock selection
    assign int_tick[0] = tmr0_tick;
    assign int_tick[1] = ctrl_all[8+`TEC_SRC_BIT] ? lxt_tick : div4_tick;
    assign int_tick[2] = ctrl_all[16+`TEC_SRC_BIT] ? lxt_tick : div4_tick;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gen_ch
            // counter 2 is the 16-bit one; the others overflow after FFH and reload
            localparam [15:0] MAXV  = (g == 2) ? `TEC_MAX16 : `TEC_MAX8;
            localparam [7:0]  CMASK = (g == 0) ? `TEC_CTRL0_MASK : `TEC_CTRL12_MASK;
            localparam [4:0]  OFF_C = (g == 0) ? `TEC_OFF_CTRL0 :
                                      (g == 1) ? `TEC_OFF_CTRL1 : `TEC_OFF_CTRL2;
            localparam [4:0]  OFF_P = (g == 0) ? `TEC_OFF_PRE0 :
                                      (g == 1) ? `TEC_OFF_PRE1 : `TEC_OFF_PRE2;

            reg  [7:0]  ctrl_q;
            reg  [15:0] pre_q;
            reg  [15:0] cnt_q;
            reg         meas_q;

            wire [1:0]  mode;
            wire        en;
            wire        edge_sel;
            wire        wr_c;
            wire        wr_p;
            wire [15:0] pre_d;
            wire        evt_tick;
            wire        start_e;
            wire        stop_e;
            wire        inc;
            wire        pwc_end;
            wire        m_evt;
            wire        m_tmr;
            wire        m_pwc;
            wire        inc_evt;
            wire        inc_tmr;
            wire        inc_pwc;

            assign mode     = ctrl_q[`TEC_MODE_HI:`TEC_MODE_LO];
            assign en       = ctrl_q[`TEC_EN_BIT];
            assign edge_sel = ctrl_q[`TEC_EDGE_BIT];
            assign wr_c     = hit(OFF_C, I_WB_ADR, wb_wr) & I_WB_SEL[0];
            assign wr_p     = hit(OFF_P, I_WB_ADR, wb_wr) & (|I_WB_SEL[1:0]);

            // one decode per mode; code 00 leaves all three low, so nothing counts
            assign m_evt    = is_mode(mode, `TEC_MODE_EVT);
            assign m_tmr    = is_mode(mode, `TEC_MODE_TMR);
            assign m_pwc    = is_mode(mode, `TEC_MODE_PWC);

            // byte-lane merge; the counter's width caps the preload
            // counters 0 and 1 keep only the low byte of a preload write
            assign pre_d = wr_p ? (((I_WB_DAT[15:0] & sel16) | (pre_q & ~sel16)) & MAXV)
                                : pre_q;

            // event edge: 0 counts rising, 1 counts falling
            assign evt_tick = edge_sel ? pin_fall[g] : pin_rise[g];

            // capture: 0 starts on falling, stops on rising; 1 the reverse
            assign start_e = edge_sel ? pin_rise[g] : pin_fall[g];
            assign stop_e  = edge_sel ? pin_fall[g] : pin_rise[g];

            // event mode takes pin edges directly, so the prescaler plays no part
            assign inc_evt = m_evt & evt_tick;
            // timer mode steps once per falling edge of its internal clock
            assign inc_tmr = m_tmr & int_tick[g];
            // capture counts inside the window; the closing edge adds nothing
            assign inc_pwc = m_pwc & meas_q & ~stop_e & int_tick[g];
            // the enable bit gates every source, so a halted counter holds
            assign inc     = en & (inc_evt | inc_tmr | inc_pwc);

            // the closing edge of a capture ends the window and drops enable
            assign pwc_end     = en & m_pwc & meas_q & stop_e;
            assign ovf_all[g]  = inc & (cnt_q == MAXV);
            assign ctrl_all[g*8 +: 8] = ctrl_q;
            assign cnt_all[g*16 +: 16] = cnt_q;

            // control: a software write wins over the capture auto-clear
            // the auto-clear drops only the enable bit; mode and edge stay set
            always @(posedge I_CORE_CLK or posedge I_SYS_RST)
            begin
                if (I_SYS_RST)
                    ctrl_q <= `TEC_CTRL_RST;
                else if (wr_c)
                    ctrl_q <= I_WB_DAT[7:0] & CMASK;
                else if (pwc_end)
                    ctrl_q[`TEC_EN_BIT] <= 1'b0;
            end

            // capture window: armed by enable, opened by the start edge
            always @(posedge I_CORE_CLK or posedge I_SYS_RST)
            begin
                if (I_SYS_RST)
                    meas_q <= 1'b0;
                else if (~en | ~m_pwc)
                    meas_q <= 1'b0;
                else if (~meas_q & start_e)
                    meas_q <= 1'b1;
                else if (meas_q & stop_e)
                    meas_q <= 1'b0;
            end

            // preload holds the reload value
            always @(posedge I_CORE_CLK or posedge I_SYS_RST)
            begin
                if (I_SYS_RST)
                    pre_q <= `TEC_PRE_RST;
                else
                    pre_q <= pre_d;
            end

            // counter: a stopped counter follows preload writes at once
            // a preload write in the overflow cycle makes the reload use the new value
            always @(posedge I_CORE_CLK or posedge I_SYS_RST)
            begin
                if (I_SYS_RST)
                    cnt_q <= `TEC_PRE_RST;
                else if (wr_p & ~en)
                    cnt_q <= pre_d;
                else if (ovf_all[g])
                    cnt_q <= pre_d;
                else if (inc)
                    cnt_q <= cnt_q + 16'h0001;
            end
        end
    endgenerate

    // interrupt enable bits, one per counter
    always @(posedge I_CORE_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            inten_q <= `TEC_INTEN_RST;
        else if (hit(`TEC_OFF_INTEN, I_WB_ADR, wb_wr) & I_WB_SEL[0])
            inten_q <= I_WB_DAT[2:0];
    end

    // masked overflows, shared by the request and wake outputs
    assign ovf_en = ovf_all & inten_q;

    // request and wake pulses; disabled counters keep counting but stay quiet
    // no sticky flag: each overflow is one pulse, so nothing needs clearing
    always @(posedge I_CORE_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            irq_q  <= 3'h0;
            wake_q <= 1'b0;
        end
        else
        begin
            irq_q  <= ovf_en;
            wake_q <= |ovf_en;
        end
    end

    // read mux: preload offsets return the live count
    // the preload itself cannot be read back once the counter has moved
    always @*
    begin
        rd_d = 32'h00000000;
        case (I_WB_ADR)
            {3'h0, `TEC_OFF_CTRL0}: rd_d = {24'h000000, ctrl_all[7:0]};
            {3'h0, `TEC_OFF_CTRL1}: rd_d = {24'h000000, ctrl_all[15:8]};
            {3'h0, `TEC_OFF_CTRL2}: rd_d = {24'h000000, ctrl_all[23:16]};
            {3'h0, `TEC_OFF_PRE0}:  rd_d = {16'h0000, cnt_all[15:0]};
            {3'h0, `TEC_OFF_PRE1}:  rd_d = {16'h0000, cnt_all[31:16]};
            {3'h0, `TEC_OFF_PRE2}:  rd_d = {16'h0000, cnt_all[47:32]};
            {3'h0, `TEC_OFF_INTEN}: rd_d = {29'h0, inten_q};
            default:                rd_d = 32'h00000000;
        endcase
    end

    // one-cycle answer; unmapped addresses ack with zero data and no effect
    // ack blocks a new request for one cycle, so a held request is answered
    // only every second cycle
    always @(posedge I_CORE_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end
        else
        begin
            wb_ack_q <= wb_req;
            if (wb_rd)
                wb_dat_q <= rd_d;
        end
    end

    assign O_WB_DAT  = wb_dat_q;
    assign O_WB_ACK  = wb_ack_q;
    assign O_TMR_IRQ = irq_q;
    assign O_WAKE    = wake_q;

endmodule // tec_top

// File: sim/tec_pin_src.sv
// partner model: external pulse source on the three timer input pins
`timescale 1ns/1ps
module tec_pin_src (
    input  wire       i_clk,  // core clock
    input  wire       i_go,   // level change request
    input  wire [1:0] i_idx,  // pin to change
    input  wire       i_lvl,  // new level
    output reg  [2:0] o_pin   // pin levels, idle low
);
    reg [2:0] hold_q;

    initial
    begin
        o_pin  = 3'h0;
        hold_q = 3'h0;
    end

    // a level is held six cycles so the synchroniser accepts it exactly once
    always @(posedge i_clk)
    begin
        if (hold_q != 3'h0)
            hold_q <= hold_q - 3'h1;
        else if (i_go)
        begin
            o_pin[i_idx] <= i_lvl;
            hold_q       <= 3'h5;
        end
    end
endmodule // tec_pin_src

// File: sim/tec_top_sva.sv
// checker for the bus answer, read-back and request outputs
`timescale 1ns/1ps
module tec_top_sva (
    input wire        I_CORE_CLK,  // core clock
    input wire        I_SYS_RST,   // async reset
    input wire        I_WB_CYC,    // cycle
    input wire        I_WB_STB,    // strobe
    input wire        I_WB_WE,     // write enable
    input wire [7:0]  I_WB_ADR,    // address
    input wire [3:0]  I_WB_SEL,    // selects
    input wire [31:0] I_WB_DAT,    // write data
    input wire [31:0] O_WB_DAT,    // read data
    input wire        O_WB_ACK,    // acknowledge
    input wire [2:0]  I_TMR_PIN,   // timer pins
    input wire        I_LXT_CLK,   // crystal
    input wire        I_PWM_EN,    // pwm enabled
    input wire [2:0]  O_TMR_IRQ,   // requests
    input wire        O_WAKE       // wake pulse
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    // a request is taken only while ack is low
    wire req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    wire rd  = req && !I_WB_WE;

    a_req_gets_ack: assert property (req |=> O_WB_ACK)
        else $error("request not answered next cycle");
    a_ack_quiet: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
        else $error("ack without request");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    a_dat_holds: assert property (!rd |=> $stable(O_WB_DAT))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (rd && I_WB_ADR == 8'h1C |=> O_WB_DAT == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl1_pad: assert property (rd && I_WB_ADR == 8'h04 |=> O_WB_DAT[2:0] == 3'h0)
        else $error("ctrl1 low bits not zero");
    a_ctrl2_pad: assert property (rd && I_WB_ADR == 8'h08 |=> O_WB_DAT[2:0] == 3'h0)
        else $error("ctrl2 low bits not zero");
    a_wake_irq: assert property (O_WAKE == (|O_TMR_IRQ))
        else $error("wake differs from requests");
endmodule // tec_top_sva

bind tec_top tec_top_sva i_tec_top_sva (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_TMR_PIN(I_TMR_PIN), .I_LXT_CLK(I_LXT_CLK), .I_PWM_EN(I_PWM_EN),
    .O_TMR_IRQ(O_TMR_IRQ), .O_WAKE(O_WAKE));

// File: sim/tec_top_tb_top.sv
// self-checking bench for the timer/event counter block
`timescale 1ns/1ps
module tec_top_tb_top;
    logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic        ack, wake, low_speed_crystal = 1'h0, pwm = 1'h0, go = 1'h0, lvl = 1'h0;
    logic [1:0]  idx = 2'h0;
    logic [2:0]  pin, irq;
    int          fails = 0, num_checks = 0, lc = 0, wc = 0;
    int          ic [3] = '{0, 0, 0};

    always #4 clk = ~clk;
    // crystal stand-in: falls every 14 core cycles, phase unrelated to the bus
    always @(posedge clk)
    begin
        lc <= (lc == 6) ? 0 : lc + 1;
        if (lc == 6) low_speed_crystal <= ~low_speed_crystal;
    end
    // count request pulses per counter, and wake pulses
    always @(posedge clk)
    begin
        for (int k = 0; k < 3; k++) if (irq[k] === 1'h1) ic[k] <= ic[k] + 1;
        if (wake === 1'h1) wc <= wc + 1;
    end

    tec_top i_tec_top (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_TMR_PIN(pin), .I_LXT_CLK(low_speed_crystal), .I_PWM_EN(pwm),
        .O_TMR_IRQ(irq), .O_WAKE(wake));
    tec_pin_src i_tec_pin_src (.i_clk(clk), .i_go(go), .i_idx(idx), .i_lvl(lvl), .o_pin(pin));

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        begin
            num_checks++;
            if (s !== e)
            begin
                $display("[FAIL] %s expected %h seen %h", nm, e, s);
                fails++;
            end
        end
    endtask

    // one classic cycle; read data taken at the ack edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        begin
            cyc  <= 1'h1;
            stb  <= 1'h1;
            we   <= w;
            adr  <= a;
            wdat <= d;
            n = 0;
            @(posedge clk);
            while (ack !== 1'h1 && n < 50)
            begin
                @(posedge clk);
                n++;
            end
            if (ack !== 1'h1)
            begin
                fails++;
                tally_and_finish;
            end
            q = rdat;
            cyc <= 1'h0;
            stb <= 1'h0;
            @(posedge clk);
        end
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        begin
            wb(1'h0, a, 32'h0, r);
            chk(nm, e, r);
        end
    endtask

    // pin change, then time for sync and count to land
    task pn(input logic [1:0] k, input logic l);
        begin
            go <= 1'h1; idx <= k; lvl <= l;
            @(posedge clk);
            go <= 1'h0;
            repeat (8) @(posedge clk);
        end
    endtask

    task t_regs;
        begin
            for (int i = 0; i < 7; i++) rc(8'(i * 4), (i < 3) ? 32'h8 : 32'h0, "reset value");
            wb(1'h1, 8'h04, 32'hFF, r);
            rc(8'h04, 32'hF8, "ctrl1 readback");
            wb(1'h1, 8'h08, 32'hFF, r);
            rc(8'h08, 32'hF8, "ctrl2 readback");
            wb(1'h1, 8'h00, 32'hFF, r);
            rc(8'h00, 32'hFF, "ctrl0 readback");
            for (int i = 0; i < 3; i++) wb(1'h1, 8'(i * 4), 32'h0, r);
            wb(1'h1, 8'h1C, 32'h5A, r);
            rc(8'h1C, 32'h0, "unmapped read");
            $display("register test done");
        end
    endtask

    task t_event;
        int s;
        begin
            wb(1'h1, 8'h18, 32'h7, r);
            wb(1'h1, 8'h00, 32'h40, r);
            wb(1'h1, 8'h0C, 32'hFE, r);
            rc(8'h0C, 32'hFE, "stopped preload");
            s = ic[0];
            wb(1'h1, 8'h00, 32'h57, r);
            pn(0, 1'h1);
            rc(8'h0C, 32'hFF, "rise counted");
            pn(0, 1'h0);
            rc(8'h0C, 32'hFF, "fall ignored");
            pn(0, 1'h1);
            rc(8'h0C, 32'hFE, "overflow reload");
            chk("irq0 pulses", s + 1, ic[0]);
            wb(1'h1, 8'h00, 32'h58, r);
            pn(0, 1'h0);
            rc(8'h0C, 32'hFF, "fall counted");
            wb(1'h1, 8'h00, 32'h48, r);
            pn(0, 1'h1);
            pn(0, 1'h0);
            rc(8'h0C, 32'hFF, "halted");
            wb(1'h1, 8'h00, 32'h18, r);
            pn(0, 1'h1);
            pn(0, 1'h0);
            rc(8'h0C, 32'hFF, "no mode");
            wb(1'h1, 8'h18, 32'h0, r);
            wb(1'h1, 8'h00, 32'h58, r);
            s = ic[0];
            pn(0, 1'h1);
            pn(0, 1'h0);
            rc(8'h0C, 32'hFE, "masked reload");
            chk("irq0 masked", s, ic[0]);
            chk("wake pulses", 32'h1, wc);
            wb(1'h1, 8'h00, 32'h0, r);
            wb(1'h1, 8'h18, 32'h7, r);
            $display("event test done");
        end
    endtask

    // cycles from enable to the first request, against a window
    task meas(input logic [7:0] ca, c, pa, input logic [15:0] p, input int k, e, t,
              input logic pw);
        int n, s;
        begin
            pwm <= pw;
            wb(1'h1, ca, {24'h0, c & 8'hEF}, r);
            wb(1'h1, pa, {16'h0, p}, r);
            s = ic[k];
            wb(1'h1, ca, {24'h0, c}, r);
            n = 0;
            while (ic[k] == s && n < 1000)
            begin
                @(posedge clk);
                n++;
            end
            if (ic[k] == s)
            begin
                fails++;
                tally_and_finish;
            end
            chk("overflow period", 32'h1, {31'h0, n >= e - t && n <= e + t});
            wb(1'h1, ca, 32'h0, r);
        end
    endtask

    task t_timer;
        begin
            meas(8'h04, 8'h90, 8'h10, 16'h00F0, 1, 64, 8, 1'h0);
            meas(8'h08, 8'h90, 8'h14, 16'hFFF0, 2, 64, 8, 1'h0);
            meas(8'h08, 8'hB0, 8'h14, 16'hFFF0, 2, 225, 25, 1'h0);
            meas(8'h00, 8'h93, 8'h0C, 16'h00F0, 0, 128, 10, 1'h0);
            meas(8'h00, 8'hB3, 8'h0C, 16'h00F0, 0, 128, 10, 1'h1);
            meas(8'h00, 8'hB0, 8'h0C, 16'h00F0, 0, 225, 25, 1'h0);
            $display("timer test done");
        end
    endtask

    task t_capture;
        logic [31:0] s;
        begin
            wb(1'h1, 8'h04, 32'hC0, r);
            wb(1'h1, 8'h10, 32'h0, r);
            wb(1'h1, 8'h04, 32'hD0, r);
            pn(1, 1'h1);
            rc(8'h10, 32'h0, "no early start");
            pn(1, 1'h0);
            repeat (40) @(posedge clk);
            pn(1, 1'h1);
            rc(8'h04, 32'hC0, "enable cleared");
            wb(1'h0, 8'h10, 32'h0, s);
            chk("pulse width", 32'h1, {31'h0, s >= 10 && s <= 15});
            pn(1, 1'h0);
            pn(1, 1'h1);
            rc(8'h10, s, "later edges ignored");
            wb(1'h1, 8'h08, 32'hC8, r);
            wb(1'h1, 8'h14, 32'h0, r);
            wb(1'h1, 8'h08, 32'hD8, r);
            pn(2, 1'h1);
            repeat (40) @(posedge clk);
            pn(2, 1'h0);
            rc(8'h08, 32'hC8, "enable cleared rev");
            wb(1'h0, 8'h14, 32'h0, s);
            chk("pulse width rev", 32'h1, {31'h0, s >= 10 && s <= 15});
            $display("capture test done");
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs;
        t_event;
        t_timer;
        t_capture;
        tally_and_finish;
    end
endmodule // tec_top_tb_top
